// File: verilog/hdst_cfg.svh
// descriptor constants for the single-tt hub descriptor block
// assumes inclusion by the block module only
`ifndef HDST_CFG_SVH
`define HDST_CFG_SVH

`define HDST_IF_LEN       8'h09
`define HDST_IF_TYPE      8'h04
`define HDST_IF_NUM       8'h00
`define HDST_IF_ALT       8'h00
`define HDST_IF_NUM_EP    8'h01
`define HDST_IF_CLASS     8'h09
`define HDST_IF_SUBCLASS  8'h00
`define HDST_IF_PROTOCOL  8'h00
`define HDST_IF_STRING    8'h00

`define HDST_EP_LEN       8'h07
`define HDST_EP_TYPE      8'h05
`define HDST_EP_ADDR      8'h81
`define HDST_EP_ATTR      8'h03
`define HDST_EP_MAXPKT    16'h0001
`define HDST_EP_INTERVAL  8'h0C

`define HDST_OS_LEN       8'h09
`define HDST_OS_TYPE      8'h07
`define HDST_OS_TOTAL     16'h0019
`define HDST_OS_NUM_IF    8'h01
`define HDST_OS_CFG_VAL   8'h01
`define HDST_OS_STRING    8'h00
`define HDST_ATTR_BUS     8'hA0
`define HDST_ATTR_SELF    8'hE0
`define HDST_ATTR_WAKE    5

`endif

// File: verilog/hdst_pkg.sv
// types for the single-tt hub descriptor block
// assumes nothing beyond the constants header
package hdst_pkg;
    typedef enum logic [1:0] {
        HDST_DESC_IF    = 2'b00,
        HDST_DESC_EP    = 2'b01,
        HDST_DESC_OTHER = 2'b10
    } hdst_desc_e;

    typedef enum logic [0:0] {
        HDST_IDLE = 1'b0,
        HDST_SEND = 1'b1
    } hdst_state_e;
endpackage

// File: verilog/hdst_descriptor.sv
// descriptor byte source for interface, status endpoint and other-speed
// assumes the control-pipe core issues requests and takes bytes on ready
`timescale 1ns/1ps
`include "hdst_cfg.svh"

// Functional notes
// - interface descriptor: nine bytes, type 04h, number and alternate zero
// - interface reports one endpoint besides endpoint zero
// - interface class 09h, subclass 00h, protocol 00h
// - interface string index is zero
// - status endpoint descriptor: seven bytes, type 05h, address 81h
// - endpoint attributes are 03h, interrupt data endpoint
// - endpoint maximum packet size is 0001h over two bytes
// - endpoint polling interval is 0Ch
// - other-speed configuration: nine bytes, type 07h
// - other-speed total length is 0019h over two bytes
// - other-speed reports one interface, configuration value one
// - other-speed configuration string index is zero
// - attributes always advertise remote wakeup
// - attributes A0h when bus powered, E0h when self powered
// - max power in 2 mA units, chosen by power source select
// - max power taken from stored power fields
module hdst_descriptor
    import hdst_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // request from control pipe
    input  wire logic        reqValid,
    input  wire logic [1:0]  reqDesc,
    input  wire logic [15:0] reqLength,
    output logic             reqReady,
    // power configuration
    input  wire logic        powerSourceSelect,
    input  wire logic [7:0]  busPoweredMaxCurrent,
    input  wire logic [7:0]  selfPoweredMaxCurrent,
    // byte stream out
    output logic             byteValid,
    output logic [7:0]       byteData,
    output logic             byteLast,
    input  wire logic        byteReady
);

    function automatic logic [7:0] descLen(input logic [1:0] d);
        case (d)
            HDST_DESC_IF:    descLen = `HDST_IF_LEN;
            HDST_DESC_EP:    descLen = `HDST_EP_LEN;
            HDST_DESC_OTHER: descLen = `HDST_OS_LEN;
            default:         descLen = 8'h00;
        endcase
    endfunction

    hdst_state_e state_r, state_nxt;
    logic [1:0]  desc_r, desc_nxt;
    logic [7:0]  idx_r, idx_nxt;
    logic [7:0]  end_r, end_nxt;
    logic [7:0]  data_r, data_nxt;
    logic [7:0]  attrByte;
    logic [7:0]  powerByte;
    logic [7:0]  romByte;
    logic [7:0]  fullLen;
    logic [7:0]  sendLen;
    logic        advance;
    // a literal cannot be part-selected, so the two-byte fields get names
    localparam logic [15:0] EP_MAX_PACKET = `HDST_EP_MAXPKT;
    localparam logic [15:0] OS_TOTAL_LEN  = `HDST_OS_TOTAL;

    // power fields are sampled live so a reload shows on the next read
    assign attrByte  = powerSourceSelect ? `HDST_ATTR_SELF
                                         : `HDST_ATTR_BUS;
    assign powerByte = powerSourceSelect ? selfPoweredMaxCurrent
                                         : busPoweredMaxCurrent;

    // byte table; index is the byte offset within the descriptor
    always_comb begin
        romByte = 8'h00;
        case (desc_nxt)
            HDST_DESC_IF: begin
                case (idx_nxt)
                    8'h00: romByte = `HDST_IF_LEN;
                    8'h01: romByte = `HDST_IF_TYPE;
                    8'h02: romByte = `HDST_IF_NUM;
                    8'h03: romByte = `HDST_IF_ALT;
                    8'h04: romByte = `HDST_IF_NUM_EP;
                    8'h05: romByte = `HDST_IF_CLASS;
                    8'h06: romByte = `HDST_IF_SUBCLASS;
                    8'h07: romByte = `HDST_IF_PROTOCOL;
                    8'h08: romByte = `HDST_IF_STRING;
                    default: romByte = 8'h00;
                endcase
            end
            HDST_DESC_EP: begin
                case (idx_nxt)
                    8'h00: romByte = `HDST_EP_LEN;
                    8'h01: romByte = `HDST_EP_TYPE;
                    8'h02: romByte = `HDST_EP_ADDR;
                    8'h03: romByte = `HDST_EP_ATTR;
                    8'h04: romByte = EP_MAX_PACKET[7:0];
                    8'h05: romByte = EP_MAX_PACKET[15:8];
                    8'h06: romByte = `HDST_EP_INTERVAL;
                    default: romByte = 8'h00;
                endcase
            end
            HDST_DESC_OTHER: begin
                case (idx_nxt)
                    8'h00: romByte = `HDST_OS_LEN;
                    8'h01: romByte = `HDST_OS_TYPE;
                    8'h02: romByte = OS_TOTAL_LEN[7:0];
                    8'h03: romByte = OS_TOTAL_LEN[15:8];
                    8'h04: romByte = `HDST_OS_NUM_IF;
                    8'h05: romByte = `HDST_OS_CFG_VAL;
                    8'h06: romByte = `HDST_OS_STRING;
                    8'h07: romByte = attrByte;
                    8'h08: romByte = powerByte;
                    default: romByte = 8'h00;
                endcase
            end
            default: romByte = 8'h00;
        endcase
    end

    assign fullLen = descLen(reqDesc);
    // zero-length or unknown requests still answer with nothing sent
    assign sendLen = (reqLength < {8'h00, fullLen}) ? reqLength[7:0]
                                                    : fullLen;
    assign advance = byteValid && byteReady;

    always_comb begin
        state_nxt = state_r;
        desc_nxt  = desc_r;
        idx_nxt   = idx_r;
        end_nxt   = end_r;
        case (state_r)
            HDST_IDLE: begin
                if (reqValid && sendLen != 8'h00) begin
                    state_nxt = HDST_SEND;
                    desc_nxt  = reqDesc;
                    idx_nxt   = 8'h00;
                    end_nxt   = sendLen - 8'h01;
                end
            end
            HDST_SEND: begin
                if (advance) begin
                    if (idx_r == end_r) begin
                        state_nxt = HDST_IDLE;
                    end else begin
                        idx_nxt = idx_r + 8'h01;
                    end
                end
            end
            default: state_nxt = HDST_IDLE;
        endcase
        data_nxt = romByte;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= HDST_IDLE;
            desc_r  <= 2'b00;
            idx_r   <= 8'h00;
            end_r   <= 8'h00;
            data_r  <= 8'h00;
        end else begin
            state_r <= state_nxt;
            desc_r  <= desc_nxt;
            idx_r   <= idx_nxt;
            end_r   <= end_nxt;
            data_r  <= data_nxt;
        end
    end

    // handshake outputs combinational, data from flip-flops
    assign reqReady  = (state_r == HDST_IDLE);
    assign byteValid = (state_r == HDST_SEND);
    assign byteData  = data_r;
    assign byteLast  = byteValid && (idx_r == end_r);

    AST_TRUNCATE: assert property (
        @(posedge clk) disable iff (!resetn)
        (reqValid && reqReady && sendLen != 8'h00)
        |=> byteValid && end_r == $past(sendLen) - 8'h01)
        else $error("reply length not cut to request");
    AST_IF_HEAD: assert property (
        @(posedge clk) disable iff (!resetn)
        (reqValid && reqReady && reqDesc == HDST_DESC_IF
         && reqLength != 16'h0000)
        |=> byteValid && idx_r == 8'h00 && byteData == 8'h09)
        else $error("interface header bytes wrong");
    AST_IF_TYPE: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_IF && idx_r == 8'h01)
        |-> byteData == 8'h04)
        else $error("interface type byte wrong");
    AST_IF_NUM: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_IF
         && (idx_r == 8'h02 || idx_r == 8'h03))
        |-> byteData == 8'h00)
        else $error("interface number or alternate not zero");
    AST_IF_NUM_EP: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_IF && idx_r == 8'h04)
        |-> byteData == 8'h01)
        else $error("interface endpoint count wrong");
    AST_IF_CLASS: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_IF && idx_r == 8'h05)
        |-> byteData == 8'h09)
        else $error("interface class wrong");
    AST_IF_PROTO: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_IF
         && (idx_r == 8'h06 || idx_r == 8'h07))
        |-> byteData == 8'h00)
        else $error("interface subclass or protocol wrong");
    AST_IF_LAST: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && byteLast && desc_r == HDST_DESC_IF
         && idx_r == 8'h08)
        |-> byteData == 8'h00)
        else $error("interface string index not zero");
    AST_EP_LEN: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_EP && idx_r == 8'h00)
        |-> byteData == 8'h07)
        else $error("endpoint length wrong");
    AST_EP_TYPE: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_EP && idx_r == 8'h01)
        |-> byteData == 8'h05)
        else $error("endpoint type wrong");
    AST_EP_ADDR: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_EP && idx_r == 8'h02)
        |-> byteData == 8'h81)
        else $error("endpoint address wrong");
    AST_EP_ATTR: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_EP && idx_r == 8'h03)
        |-> byteData == 8'h03)
        else $error("endpoint attributes wrong");
    AST_EP_PKT: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_EP && idx_r == 8'h04)
        |-> byteData == 8'h01)
        else $error("max packet low byte wrong");
    AST_EP_PKT_HI: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_EP && idx_r == 8'h05)
        |-> byteData == 8'h00)
        else $error("max packet high byte wrong");
    AST_EP_INT: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_EP && idx_r == 8'h06)
        |-> byteData == 8'h0C && byteLast)
        else $error("polling interval wrong");
    AST_OS_LEN: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_OTHER && idx_r == 8'h00)
        |-> byteData == 8'h09)
        else $error("other-speed length wrong");
    AST_OS_TYPE: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_OTHER && idx_r == 8'h01)
        |-> byteData == 8'h07)
        else $error("other-speed type wrong");
    AST_OS_TOTAL: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_OTHER && idx_r == 8'h02)
        |-> byteData == 8'h19)
        else $error("total length low byte wrong");
    AST_OS_TOTAL_HI: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_OTHER && idx_r == 8'h03)
        |-> byteData == 8'h00)
        else $error("total length high byte wrong");
    AST_OS_COUNTS: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_OTHER
         && (idx_r == 8'h04 || idx_r == 8'h05))
        |-> byteData == 8'h01)
        else $error("interface count or config value wrong");
    AST_OS_STRING: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_OTHER && idx_r == 8'h06)
        |-> byteData == 8'h00)
        else $error("configuration string index not zero");
    AST_WAKE: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_OTHER && idx_r == 8'h07)
        |-> byteData[`HDST_ATTR_WAKE])
        else $error("remote wakeup not advertised");
    AST_ATTR: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_OTHER && idx_r == 8'h07
         && $stable(powerSourceSelect))
        |-> byteData == ($past(powerSourceSelect) ? 8'hE0 : 8'hA0))
        else $error("attributes byte wrong");
    AST_ATTR_ONLY: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_OTHER && idx_r == 8'h07)
        |-> byteData == 8'hA0 || byteData == 8'hE0)
        else $error("attributes byte outside the two values");
    AST_POWER: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && desc_r == HDST_DESC_OTHER && idx_r == 8'h08
         && $stable(powerSourceSelect))
        |-> byteData == ($past(powerSourceSelect)
                         ? $past(selfPoweredMaxCurrent)
                         : $past(busPoweredMaxCurrent)))
        else $error("max power byte wrong");
    AST_HOLD: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && !byteReady)
        |=> byteValid && $stable(idx_r))
        else $error("byte dropped while consumer stalled");
    AST_END: assert property (
        @(posedge clk) disable iff (!resetn)
        (byteValid && byteReady && byteLast)
        |=> reqReady && !byteValid)
        else $error("reply did not end after last byte");
    AST_ZERO: assert property (
        @(posedge clk) disable iff (!resetn)
        (reqValid && reqReady && sendLen == 8'h00)
        |=> reqReady && !byteValid)
        else $error("empty reply sent bytes");

endmodule // hdst_descriptor

// File: dv/hdst_host_model.sv
// host model: issues descriptor requests and collects returned bytes
// assumes one shared clock; block outputs settled by the falling edge
`timescale 1ns/1ps
module hdst_host_model (
    // clock
    input  wire logic        clk,
    // request side
    output logic             reqValid,
    output logic [1:0]       reqDesc,
    output logic [15:0]      reqLength,
    input  wire logic        reqReady,
    // byte side
    input  wire logic        byteValid,
    input  wire logic [7:0]  byteData,
    input  wire logic        byteLast,
    output logic             byteReady
);
    logic [7:0] got[$];
    int         lastIdx = -1;
    initial begin
        reqValid = 1'b0;
        reqDesc = 2'h0;
        reqLength = 16'h0000;
        byteReady = 1'b1;
    end
    // call just after a rising edge; requests go through the handshake
    task automatic request(input logic [1:0] d, input logic [15:0] n,
                           input bit slow);
        bit k;
        bit l;
        logic [7:0] b;
        l = 1'b0;
        lastIdx = -1;
        got.delete();
        reqValid <= 1'b1;
        reqDesc <= d;
        reqLength <= n;
        byteReady <= 1'b1;
        do begin
            @(negedge clk);
            k = reqReady;
            @(posedge clk);
        end while (!k);
        // released lines must not keep their old value
        reqValid <= 1'b0;
        reqDesc <= ~d;
        reqLength <= ~n;
        for (int i = 0; i < 40 && !l; i++) begin
            @(negedge clk);
            k = byteValid && byteReady;
            b = byteData;
            l = k && byteLast;
            @(posedge clk);
            if (k && l) lastIdx = got.size();
            if (k) got.push_back(b);
            // no toggle on the final edge: the next request sets it then
            if (slow && !l) byteReady <= ~byteReady;
        end
    endtask
endmodule // hdst_host_model

// File: dv/tb_top.sv
// top bench: descriptor block facing the host model, scenario tasks
// assumes the block checks its own timing with inline assertions
`timescale 1ns/1ps
module tb_top;
    logic       clk;
    logic       resetn;
    logic       powerSourceSelect;
    logic [7:0] busPoweredMaxCurrent;
    logic [7:0] selfPoweredMaxCurrent;
    logic       reqValid, reqReady, byteValid, byteLast, byteReady;
    logic [1:0] reqDesc;
    logic [15:0] reqLength;
    logic [7:0] byteData;
    logic [7:0] ifQ[$];
    logic [7:0] epQ[$];
    int errors = 0;
    int cmp_count = 0;
    hdst_descriptor dut (.clk(clk), .resetn(resetn), .reqValid(reqValid),
        .reqDesc(reqDesc), .reqLength(reqLength), .reqReady(reqReady),
        .powerSourceSelect(powerSourceSelect),
        .busPoweredMaxCurrent(busPoweredMaxCurrent),
        .selfPoweredMaxCurrent(selfPoweredMaxCurrent),
        .byteValid(byteValid), .byteData(byteData), .byteLast(byteLast),
        .byteReady(byteReady));
    hdst_host_model host (.clk(clk), .reqValid(reqValid), .reqDesc(reqDesc),
        .reqLength(reqLength), .reqReady(reqReady), .byteValid(byteValid),
        .byteData(byteData), .byteLast(byteLast), .byteReady(byteReady));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic test_done();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // reply length is the shorter of request and descriptor
    task automatic run_cmp(input logic [1:0] d, input logic [15:0] n,
                           input bit slow, input logic [7:0] e[$]);
        int m;
        m = (n < e.size()) ? n : e.size();
        host.request(d, n, slow);
        check(16'(host.got.size()), 16'(m));
        check(16'(host.lastIdx + 1), 16'(m));
        for (int i = 0; i < m && i < host.got.size(); i++)
            check({8'h00, host.got[i]}, {8'h00, e[i]});
    endtask
    task automatic t_other();
        logic [7:0] q[$];
        for (int s = 0; s < 2; s++) begin
            powerSourceSelect <= s[0];
            busPoweredMaxCurrent <= 8'h32 + 8'(s);
            selfPoweredMaxCurrent <= 8'h05 + 8'(s);
            q = {8'h09, 8'h07, 8'h19, 8'h00, 8'h01, 8'h01, 8'h00,
                 s ? 8'hE0 : 8'hA0, s ? 8'h06 : 8'h32};
            @(posedge clk);
            run_cmp(2, 9, s[0], q);
            check(16'(host.got[7][5]), 16'h0001);
        end
    endtask
    task automatic t_trunc();
        logic [7:0] none[$];
        run_cmp(1, 6, 1'b0, epQ);
        run_cmp(0, 3, 1'b1, ifQ);
        run_cmp(0, 0, 1'b0, ifQ);
        run_cmp(3, 5, 1'b0, none);
    endtask
    initial begin
        resetn = 1'b0;
        powerSourceSelect = 1'b0;
        busPoweredMaxCurrent = 8'h00;
        selfPoweredMaxCurrent = 8'h00;
        ifQ = {8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00, 8'h00};
        epQ = {8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'h0C};
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        check(16'(reqReady), 16'h0001);
        check(16'(byteValid), 16'h0000);
        @(posedge clk);
        run_cmp(0, 9, 1'b0, ifQ);
        run_cmp(1, 16'hFFFF, 1'b1, epQ);
        t_other();
        t_trunc();
        test_done();
    end
    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        test_done();
    end
endmodule // tb_top
